//--- inc/gpp_cfg.svh
/*
 Register offsets, reset values, field positions and timing counts of the
 general-purpose port block. Assumes a 16-bit register window decoded from
 the low half of the bus address.
*/
// Overview of operation
// - One bidirectional pin that can also take an external interrupt request.
// - In port mode, the group-3 direction bit sets that pin input or output.
// - Group-3 pull-up bit set connects the on-chip pull-up to that pin while it is an input.
// - In control mode the pin requests interrupts on rising, falling or both edges.
// - One input-only pin, no driver, readable as a level when not reset.
// - At power-on the input-only pin is reset; port use is configured later.
// - Reset pin takes active-low system reset, always active at power-on.
// - Each of the two pins switches between port and control mode on its own.
// - Eight-bit bidirectional port, each bit's direction set by group-4 register.
// - Each eight-bit port pin gets a pull-up when its group-4 pull-up bit is set and the pin is an input.
// - During reset the two oscillator-shared pins are held pulled down.
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

`define GPP_OFS_P3_DATA 16'hff00
`define GPP_OFS_P4_DATA 16'hff04
`define GPP_OFS_DIR3 16'hff08
`define GPP_OFS_DIR4 16'hff0c
`define GPP_OFS_PU3 16'hff10
`define GPP_OFS_PU4 16'hff14
`define GPP_OFS_MODE 16'hff18
`define GPP_OFS_EDGE_SEL 16'hffec

`define GPP_RST_LATCH3 1'h0
`define GPP_RST_LATCH4 8'h00
`define GPP_RST_DIR3 1'h1
`define GPP_RST_DIR4 8'hff
`define GPP_RST_PU3 1'h0
`define GPP_RST_PU4 8'h00
`define GPP_RST_MODE 2'h0
`define GPP_RST_EDGE_SEL 8'h00
`define GPP_EDGE_SEL_MASK 8'h3c

`define GPP_BIT_P3_IRQ 2
`define GPP_BIT_P3_RST 4
`define GPP_BIT_MODE_IRQ 0
`define GPP_BIT_MODE_RSTPIN 1
`define GPP_BIT_ES_LO 4
`define GPP_BIT_ES_HI 5

`define GPP_HSIZE_WORD 3'h2
`define GPP_SYNC_STAGES 3

`endif

//--- inc/gpp_pkg.sv
/*
 Types of the general-purpose port block: edge selection codes, bus phase
 states and the captured address phase. Assumes gpp_cfg.svh for constants.
*/
package gpp_pkg;

	typedef enum logic [1:0] {
		GPP_EDGE_FALL = 2'h0,
		GPP_EDGE_RISE = 2'h1,
		GPP_EDGE_NONE = 2'h2,
		GPP_EDGE_BOTH = 2'h3
	} gpp_edge_t;

	typedef enum logic {
		GPP_BUS_IDLE = 1'h0,
		GPP_BUS_READ = 1'h1
	} gpp_bus_st_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
	} gpp_ahb_ap_t;

endpackage

//--- core/gpp_port.sv
/*
 General-purpose port logic: a one-bit pin with external interrupt input,
 an input-only pin shared with the reset function, an eight-bit port and
 the reset pull-downs of the oscillator-shared pins, behind an AHB-Lite slave.
 Assumes one 25 MHz clock, a synchronous active-high reset, and pad cells
 outside that resolve out/oe_n/pu_en/pd_en into wire levels.
*/
// Implementation choice: the AHB-Lite slave port.
`include "gpp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module gpp_port
	import gpp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic irq_capable_pin_in,
	output logic irq_capable_pin_out,
	output logic irq_capable_pin_oe_n,
	output logic irq_capable_pin_pu_en,
	input wire logic input_only_reset_pin_in,
	input wire logic [7:0] eight_bit_port_pins_in,
	output logic [7:0] eight_bit_port_pins_out,
	output logic [7:0] eight_bit_port_pins_oe_n,
	output logic [7:0] eight_bit_port_pins_pu_en,
	output logic osc_in_pin_pd_en,
	output logic osc_out_pin_pd_en,
	output logic ext_irq_line1,
	output logic pin_reset_req
);

	localparam int NPIN = 10;
	localparam int IX_P4 = 0;
	localparam int IX_IRQ = 8;
	localparam int IX_RST = 9;

	// an input bit reads the pad level, an output bit reads its own latch
	function automatic logic [7:0] gpp_view(
		input logic [7:0] is_in,
		input logic [7:0] latch,
		input logic [7:0] pin
	);
		gpp_view = (is_in & pin) | (~is_in & latch);
	endfunction

	// address match of the captured data phase against one register offset
	function automatic logic gpp_hit(
		input logic [15:0] addr,
		input logic [15:0] ofs
	);
		gpp_hit = (addr == ofs);
	endfunction

	// places the single group-3 control bit at its byte position
	function automatic logic [7:0] gpp_p3_field(
		input logic b
	);
		gpp_p3_field = 8'(b) << `GPP_BIT_P3_IRQ;
	endfunction

	// bus slave state
	gpp_ahb_ap_t ap;
	gpp_bus_st_t bus_st;
	gpp_bus_st_t next_bus_st;

	// software registers
	logic latch3;
	logic [7:0] latch4;
	logic dir3;
	logic [7:0] dir4;
	logic pu3;
	logic [7:0] pu4;
	logic mode_irq_ctl;
	logic mode_rstpin_port;
	logic [7:0] edge_sel;

	// pad input synchronisers and filtered levels
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic [NPIN-1:0] sync3;
	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] next_pin_lvl;
	logic irq_prev;

	// address phase decode
	wire word_size = (hsize == `GPP_HSIZE_WORD);
	wire ap_take = hsel & hready & htrans[1];
	wire ap_ok = ap_take & word_size;
	wire rd_start = ap_ok & ~hwrite;

	// data phase write decode
	wire wr_en = ap.valid & ap.write;
	// the same decode serves the write strobes and the read multiplexer
	wire hit_p3 = gpp_hit(ap.addr, `GPP_OFS_P3_DATA);
	wire hit_p4 = gpp_hit(ap.addr, `GPP_OFS_P4_DATA);
	wire hit_dir3 = gpp_hit(ap.addr, `GPP_OFS_DIR3);
	wire hit_dir4 = gpp_hit(ap.addr, `GPP_OFS_DIR4);
	wire hit_pu3 = gpp_hit(ap.addr, `GPP_OFS_PU3);
	wire hit_pu4 = gpp_hit(ap.addr, `GPP_OFS_PU4);
	wire hit_mode = gpp_hit(ap.addr, `GPP_OFS_MODE);
	wire hit_edge = gpp_hit(ap.addr, `GPP_OFS_EDGE_SEL);
	wire we_p3 = wr_en & hit_p3;
	wire we_p4 = wr_en & hit_p4;
	wire we_dir3 = wr_en & hit_dir3;
	wire we_dir4 = wr_en & hit_dir4;
	wire we_pu3 = wr_en & hit_pu3;
	wire we_pu4 = wr_en & hit_pu4;
	wire we_mode = wr_en & hit_mode;
	wire we_edge = wr_en & hit_edge;

	always_comb begin
		next_bus_st = GPP_BUS_IDLE;
		if (bus_st == GPP_BUS_IDLE && rd_start) begin
			next_bus_st = GPP_BUS_READ;
		end
	end

	// one wait state on reads so that a write in the cycle before is seen
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_st <= GPP_BUS_IDLE;
			hreadyout <= 1'h1;
			hresp <= 1'h0;
		end else begin
			bus_st <= next_bus_st;
			hreadyout <= (next_bus_st == GPP_BUS_IDLE);
			hresp <= 1'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ap <= '0;
		end else if (ap_take) begin
			ap.valid <= word_size;
			ap.write <= hwrite;
			ap.addr <= haddr[15:0];
		end else begin
			ap.valid <= 1'h0;
		end
	end

	// register reads
	wire irq_in_mode = dir3 | mode_irq_ctl;
	wire [7:0] p3_mask = 8'h01 << `GPP_BIT_P3_IRQ;
	wire [7:0] p3_pins = {3'h0, pin_lvl[IX_RST], 1'h0, pin_lvl[IX_IRQ], 2'h0};
	wire [7:0] p3_latch = gpp_p3_field(latch3);
	wire [7:0] dir3_rd = gpp_p3_field(dir3);
	wire [7:0] pu3_rd = gpp_p3_field(pu3);
	wire [7:0] p3_dir = irq_in_mode ? p3_mask : 8'h00;
	wire [7:0] p3_rd = gpp_view(p3_dir, p3_latch, p3_pins) | (p3_pins & ~p3_mask);
	wire [7:0] p4_rd = gpp_view(dir4, latch4, pin_lvl[IX_P4 +: 8]);
	wire [7:0] mode_rd = {6'h0, mode_rstpin_port, mode_irq_ctl};
	wire [7:0] rd_byte =
		hit_p3 ? p3_rd :
		hit_p4 ? p4_rd :
		hit_dir3 ? dir3_rd :
		hit_dir4 ? dir4 :
		hit_pu3 ? pu3_rd :
		hit_pu4 ? pu4 :
		hit_mode ? mode_rd :
		hit_edge ? edge_sel :
		8'h00;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hrdata <= 32'h0;
		end else if (bus_st == GPP_BUS_READ) begin
			hrdata <= {24'h0, rd_byte};
		end
	end

	// port 3 control
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			latch3 <= `GPP_RST_LATCH3;
			dir3 <= `GPP_RST_DIR3;
			pu3 <= `GPP_RST_PU3;
		end else begin
			if (we_p3) begin
				latch3 <= hwdata[`GPP_BIT_P3_IRQ];
			end
			if (we_dir3) begin
				dir3 <= hwdata[`GPP_BIT_P3_IRQ];
			end
			if (we_pu3) begin
				pu3 <= hwdata[`GPP_BIT_P3_IRQ];
			end
		end
	end

	// port 4 control
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			latch4 <= `GPP_RST_LATCH4;
			dir4 <= `GPP_RST_DIR4;
			pu4 <= `GPP_RST_PU4;
		end else begin
			if (we_p4) begin
				latch4 <= hwdata[7:0];
			end
			if (we_dir4) begin
				dir4 <= hwdata[7:0];
			end
			if (we_pu4) begin
				pu4 <= hwdata[7:0];
			end
		end
	end

	// mode bits; reset always restores the reset function of the shared pin
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			{mode_rstpin_port, mode_irq_ctl} <= `GPP_RST_MODE;
			edge_sel <= `GPP_RST_EDGE_SEL;
		end else begin
			if (we_mode) begin
				mode_irq_ctl <= hwdata[`GPP_BIT_MODE_IRQ];
				mode_rstpin_port <= hwdata[`GPP_BIT_MODE_RSTPIN];
			end
			if (we_edge) begin
				edge_sel <= hwdata[7:0] & `GPP_EDGE_SEL_MASK;
			end
		end
	end

	// three-stage synchronisers; a level counts once stages two and three agree
	assign pin_raw[IX_P4 +: 8] = eight_bit_port_pins_in;
	assign pin_raw[IX_IRQ] = irq_capable_pin_in;
	assign pin_raw[IX_RST] = input_only_reset_pin_in;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_filt
			assign next_pin_lvl[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pin_lvl[gi];
		end
	endgenerate

	// idle-high reset values keep the reset pin from firing right after rst
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1 <= {NPIN{1'h1}};
			sync2 <= {NPIN{1'h1}};
			sync3 <= {NPIN{1'h1}};
			pin_lvl <= {NPIN{1'h1}};
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_lvl <= next_pin_lvl;
		end
	end

	// edge detection on the interrupt-capable pin
	gpp_edge_t edge_mode;
	assign edge_mode = gpp_edge_t'(edge_sel[`GPP_BIT_ES_HI:`GPP_BIT_ES_LO]);
	wire irq_lvl = pin_lvl[IX_IRQ];
	wire irq_rise = irq_lvl & ~irq_prev;
	wire irq_fall = ~irq_lvl & irq_prev;
	wire edge_ok =
		(edge_mode == GPP_EDGE_RISE) ? irq_rise :
		(edge_mode == GPP_EDGE_FALL) ? irq_fall :
		(edge_mode == GPP_EDGE_BOTH) ? (irq_rise | irq_fall) :
		1'h0;
	wire next_irq = mode_irq_ctl & edge_ok;

	// the previous level tracks in every mode, so entering control mode
	// never manufactures an edge out of a stale sample
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_prev <= 1'h1;
			ext_irq_line1 <= 1'h0;
		end else begin
			irq_prev <= irq_lvl;
			ext_irq_line1 <= next_irq;
		end
	end

	// pad drivers; control mode forces the pin to input
	wire next_irq_oe_n = irq_in_mode;
	wire next_irq_pu = pu3 & irq_in_mode;
	wire [7:0] next_p4_pu = pu4 & dir4;
	wire next_rst_req = ~mode_rstpin_port & ~pin_lvl[IX_RST];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_capable_pin_out <= `GPP_RST_LATCH3;
			irq_capable_pin_oe_n <= 1'h1;
			irq_capable_pin_pu_en <= 1'h0;
			eight_bit_port_pins_out <= `GPP_RST_LATCH4;
			eight_bit_port_pins_oe_n <= 8'hff;
			eight_bit_port_pins_pu_en <= 8'h00;
			osc_in_pin_pd_en <= 1'h1;
			osc_out_pin_pd_en <= 1'h1;
			pin_reset_req <= 1'h0;
		end else begin
			irq_capable_pin_out <= latch3;
			irq_capable_pin_oe_n <= next_irq_oe_n;
			irq_capable_pin_pu_en <= next_irq_pu;
			eight_bit_port_pins_out <= latch4;
			eight_bit_port_pins_oe_n <= dir4;
			eight_bit_port_pins_pu_en <= next_p4_pu;
			osc_in_pin_pd_en <= 1'h0;
			osc_out_pin_pd_en <= 1'h0;
			pin_reset_req <= next_rst_req;
		end
	end

endmodule

`default_nettype wire

//--- dv/gpp_pads.sv
/*
 Board model around the port pins: resolves pad levels from the block's
 drivers, the board's own drivers and the pull resistors.
 Assumes the bench drives the board side by non-blocking assignment.
*/
`timescale 1ns/1ps
`default_nettype none

module gpp_pads (
	input wire logic irq_out,
	input wire logic irq_oe_n,
	input wire logic irq_pu_en,
	input wire logic irq_drv,
	input wire logic irq_drv_en,
	input wire logic [7:0] p4_out,
	input wire logic [7:0] p4_oe_n,
	input wire logic [7:0] p4_pu_en,
	input wire logic [7:0] p4_drv,
	input wire logic [7:0] p4_drv_en,
	input wire logic rst_pin_low,
	output logic irq_pin,
	output logic [7:0] p4_pin,
	output logic rst_pin
);
	// an undriven pin with no pull-up reads opposite the latch, so a float never matches
	assign irq_pin = !irq_oe_n ? irq_out : irq_drv_en ? irq_drv : irq_pu_en | ~irq_out;
	assign p4_pin = (~p4_oe_n & p4_out) | (p4_oe_n & p4_drv_en & p4_drv) |
		(p4_oe_n & ~p4_drv_en & (p4_pu_en | ~p4_out));
	assign rst_pin = !rst_pin_low;
endmodule

`default_nettype wire

//--- dv/gpp_port_asserts.sv
/*
 Timing checks on the ports of the general-purpose port block.
 Assumes one clock and the synchronous active-high reset of the block.
*/
`timescale 1ns/1ps
`default_nettype none

module gpp_port_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq_capable_pin_oe_n,
	input wire logic irq_capable_pin_pu_en,
	input wire logic input_only_reset_pin_in,
	input wire logic [7:0] eight_bit_port_pins_oe_n,
	input wire logic [7:0] eight_bit_port_pins_pu_en,
	input wire logic osc_in_pin_pd_en,
	input wire logic osc_out_pin_pd_en,
	input wire logic ext_irq_line1,
	input wire logic pin_reset_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_req; hsel && hready && htrans[1] && hsize == 3'h2; endsequence
	sequence s_rd; s_req ##0 !hwrite; endsequence
	sequence s_wr; s_req ##0 hwrite; endsequence
	property p_rd_wait; s_rd |=> !hreadyout ##1 hreadyout; endproperty
	property p_wr_fast; s_wr |=> hreadyout; endproperty
	property p_okay; !hresp; endproperty
	property p_pd_rst; disable iff (1'b0) rst |=> osc_in_pin_pd_en && osc_out_pin_pd_en; endproperty
	property p_pd_run; !$past(rst) |-> !osc_in_pin_pd_en && !osc_out_pin_pd_en; endproperty
	property p_pu3; irq_capable_pin_pu_en |-> irq_capable_pin_oe_n; endproperty
	property p_pu4; (eight_bit_port_pins_pu_en & ~eight_bit_port_pins_oe_n) == 8'h00; endproperty
	property p_irq_pulse; ext_irq_line1 |=> !ext_irq_line1; endproperty
	property p_irq_ctl; ext_irq_line1 |-> irq_capable_pin_oe_n; endproperty
	property p_rst_req; $rose(pin_reset_req) |-> !$past(input_only_reset_pin_in, 4); endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
	a_okay: assert property (p_okay) else $error("error response");
	a_pd_rst: assert property (p_pd_rst) else $error("no pull-down in reset");
	a_pd_run: assert property (p_pd_run) else $error("pull-down after reset");
	a_pu3: assert property (p_pu3) else $error("pull-up on driven pin");
	a_pu4: assert property (p_pu4) else $error("pull-up on driven port bit");
	a_irq_pulse: assert property (p_irq_pulse) else $error("request too long");
	a_irq_ctl: assert property (p_irq_ctl) else $error("request while pin driven");
	a_rst_req: assert property (p_rst_req) else $error("reset without low pin");
endmodule

bind gpp_port gpp_port_asserts u_gpp_chk (.*);

`default_nettype wire

//--- dv/tb_top.sv
/*
 Self-checking bench of the general-purpose port block: register access
 over AHB-Lite, port and pin behaviour through a board model.
 Assumes gpp_cfg.svh on the include path.
*/
`include "gpp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, irq_out, irq_oe_n, irq_pu_en, irq_pin, rst_pin, pd_in, pd_out;
	logic ext_irq, rst_req, irq_drv = 1'b1, irq_drv_en = 1'b1, rst_pin_low = 1'b0;
	logic [7:0] p4_out, p4_oe_n, p4_pu_en, p4_pin, p4_drv = 8'h00, p4_drv_en = 8'h00;
	logic [7:0] d, p, l, b, e;
	int n_errors = 0, cmp_count = 0, irq_cnt = 0, n0, seed = 32'haa92;
	int exp_irq[5] = '{1, 1, 0, 2, 0};

	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (ext_irq === 1'b1) irq_cnt <= irq_cnt + 1;

	gpp_port dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq_capable_pin_in(irq_pin), .irq_capable_pin_out(irq_out),
		.irq_capable_pin_oe_n(irq_oe_n), .irq_capable_pin_pu_en(irq_pu_en),
		.input_only_reset_pin_in(rst_pin), .eight_bit_port_pins_in(p4_pin),
		.eight_bit_port_pins_out(p4_out), .eight_bit_port_pins_oe_n(p4_oe_n),
		.eight_bit_port_pins_pu_en(p4_pu_en), .osc_in_pin_pd_en(pd_in),
		.osc_out_pin_pd_en(pd_out), .ext_irq_line1(ext_irq), .pin_reset_req(rst_req));
	gpp_pads u_pads (.irq_out(irq_out), .irq_oe_n(irq_oe_n), .irq_pu_en(irq_pu_en),
		.irq_drv(irq_drv), .irq_drv_en(irq_drv_en), .p4_out(p4_out), .p4_oe_n(p4_oe_n),
		.p4_pu_en(p4_pu_en), .p4_drv(p4_drv), .p4_drv_en(p4_drv_en),
		.rst_pin_low(rst_pin_low), .irq_pin(irq_pin), .p4_pin(p4_pin), .rst_pin(rst_pin));

	task automatic pause(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] dat);
		hsel <= 1'b1; haddr <= {16'h0, a}; htrans <= 2'h2; hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, dat};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] ex);
		bus(1'b0, a, 8'h00);
		`CHK("read data", {24'h0, ex}, hrdata)
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// input bits read the pad; undriven ones float opposite the latch unless pulled up
	function automatic logic [7:0] p4_exp(logic [7:0] d, p, l, b, e);
		return (d & ((e & b) | (~e & (p | ~l)))) | (~d & l);
	endfunction

	initial begin
		pause(2);
		`CHK("pd", 2'b11, {pd_in, pd_out})
		`CHK("oe4", 8'hff, p4_oe_n)
		`CHK("oe3", 1'b1, irq_oe_n)
		rst <= 1'b0;
		rd(`GPP_OFS_EDGE_SEL, 8'h00);
		`CHK("pd", 2'b00, {pd_in, pd_out})
		rd(`GPP_OFS_DIR4, 8'hff);
		rd(`GPP_OFS_PU4, 8'h00);
		bus(1'b1, 16'hff30, 8'hff);
		rd(16'hff30, 8'h00);
		bus(1'b1, `GPP_OFS_EDGE_SEL, 8'hff);
		rd(`GPP_OFS_EDGE_SEL, 8'h3c);
		for (int i = 0; i < 14; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			p = 8'($random(seed)); l = 8'($random(seed));
			b = 8'($random(seed)); e = 8'($random(seed));
			p4_drv <= b; p4_drv_en <= e;
			bus(1'b1, `GPP_OFS_DIR4, d); bus(1'b1, `GPP_OFS_PU4, p); bus(1'b1, `GPP_OFS_P4_DATA, l);
			pause(6);
			`CHK("oe4", d, p4_oe_n)
			`CHK("pu4", p & d, p4_pu_en)
			`CHK("out4", l, p4_out)
			rd(`GPP_OFS_P4_DATA, p4_exp(d, p, l, b, e));
		end
		bus(1'b1, `GPP_OFS_DIR3, 8'h00); bus(1'b1, `GPP_OFS_P3_DATA, 8'h04); pause(2);
		`CHK("oe3", 1'b0, irq_oe_n)
		`CHK("out3", 1'b1, irq_out)
		bus(1'b1, `GPP_OFS_DIR3, 8'h04); bus(1'b1, `GPP_OFS_PU3, 8'h04);
		irq_drv_en <= 1'b0; pause(6);
		`CHK("pu3", 2'b11, {irq_pu_en, irq_oe_n})
		rd(`GPP_OFS_P3_DATA, 8'h14);
		irq_drv_en <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			bus(1'b1, `GPP_OFS_MODE, (c < 4) ? 8'h01 : 8'h00);
			bus(1'b1, `GPP_OFS_EDGE_SEL, {2'h0, ((c < 4) ? c[1:0] : 2'h3), 4'h0});
			pause(8); n0 = irq_cnt;
			irq_drv <= 1'b0; pause(8); irq_drv <= 1'b1; pause(8);
			`CHK("irq count", exp_irq[c], irq_cnt - n0)
		end
		rst_pin_low <= 1'b1; pause(8);
		`CHK("rst req", 1'b1, rst_req)
		rst_pin_low <= 1'b0; pause(8);
		`CHK("rst req", 1'b0, rst_req)
		bus(1'b1, `GPP_OFS_MODE, 8'h02);
		rst_pin_low <= 1'b1; pause(8);
		`CHK("rst req", 1'b0, rst_req)
		rd(`GPP_OFS_P3_DATA, 8'h04);
		rst_pin_low <= 1'b0; pause(8);
		rd(`GPP_OFS_P3_DATA, 8'h14);
		rst <= 1'b1; pause(2);
		`CHK("pd", 2'b11, {pd_in, pd_out})
		rst <= 1'b0;
		rd(`GPP_OFS_MODE, 8'h00);
		rst_pin_low <= 1'b1; pause(8);
		`CHK("rst req", 1'b1, rst_req)
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		print_verdict;
	end
endmodule

`default_nettype wire
